// File: shared/aes_seq_consts.vh
// Purpose: Shared constants for the AES demo sequencer and its display path.
// Assumes: 40 MHz system clock; serial display at 57600 baud.
// Notes: Message block contents and the counter start value are arbitrary demo data.
`ifndef AES_SEQ_CONSTS_VH
`define AES_SEQ_CONSTS_VH

// Operation codes on the command port.
`define OP_ENCRYPT 2'h0
`define OP_DECRYPT 2'h1
`define OP_CBC_MAC 2'h2

// Cipher mode field of a service request.
`define MODE_ECB 2'h0
`define MODE_CBC 2'h1
`define MODE_OFB 2'h2
`define MODE_CTR 2'h3

// Message source: four 128-bit blocks, the last one carries the switch byte.
`define MSG_BLOCKS 3'h4
`define MSG_BLOCK0 128'h00112233445566778899aabbccddeeff
`define MSG_BLOCK1 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0
`define MSG_BLOCK2 128'h13579bdf02468ace13579bdf02468ace
`define MSG_BLOCK3_HI 120'h6d6573736167652d73776974636800
`define ZERO_IV 128'h00000000000000000000000000000000
`define COUNTER_START 128'h00000000000000000000000000000000
`define COUNTER_STEP 128'h00000000000000000000000000000001

// Text formatting.
`define RESULT_BYTES 5'h10
`define LINE_CHARS 6'h22
`define CHAR_ZERO 8'h30
`define CHAR_A_LOWER 8'h61
`define CHAR_CR 8'h0d
`define CHAR_LF 8'h0a
`define DIGIT_TEN 4'ha

// Serial display framing and timing.
`define CLK_HZ 40000000
`define BAUD_RATE 57600
// Bit time in clock cycles: the clock rate over the baud rate, rounded down, sized for the baud counter.
`define BIT_CYCLES 10'h2b6
`define FRAME_BITS 4'ha
`define IDLE_LINE 1'b1

// Character buffer geometry.
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_ADDR 4

`endif

// File: rtl/char_fifo.v
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; in_ready low when full, out_valid low when empty.
// Notes: A push and a pop in the same cycle leave the level unchanged.
`timescale 1ns/1ps
module char_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock, // System clock.
  input wire rst, // Asynchronous reset, active high.
  input wire in_valid, // Writer offers a word.
  output wire in_ready, // Room for a word.
  input wire [WIDTH-1:0] in_data, // Word offered.
  output wire out_valid, // A word is available.
  input wire out_ready, // Reader takes the word.
  output wire [WIDTH-1:0] out_data // Oldest word.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] level_q;
  wire push;
  wire pop;

  assign in_ready = (level_q != DEPTH[AW:0]);
  assign out_valid = (level_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        level_q <= level_q + 1'b1;
      end else if (pop && !push) begin
        level_q <= level_q - 1'b1;
      end
    end
  end
endmodule

// File: rtl/aes_demo_seq.v
// Purpose: Sequencer that drives an AES service core and prints results as hex text.
// Assumes: The service core pulses svc_done for one cycle with svc_result valid.
// Notes: Message lengths are whole 128-bit blocks; no padding is ever added.
`timescale 1ns/1ps
`include "aes_seq_consts.vh"

// Contract
// R1 - Byte prints upper nibble, then lower nibble.
// R2 - Digits map to 0-9 then a-f.
// R3 - Multi-byte values print first byte first.
// R4 - Plaintext is incrementing big-endian counter.
// R5 - Decryption uses most recent ciphertext.
// R6 - CBC-MAC uses CBC mode, zero first IV.
// R7 - Later blocks chain on previous ciphertext.
// R8 - Every CBC-MAC request carries its IV.
// R9 - Messages are whole 128-bit blocks only.
// R10 - Four messages; one follows external switches. The code has one message of four blocks, and block 3 carries the switch byte.
// R11 - Block counter ends at message length; block_q stops at MSG_BLOCKS - 1.
// R12 - Engine takes 128-bit blocks, 128/256-bit keys.
// R13 - Engine offers ECB, CBC, OFB, CTR.
// R14 - Serial port 57600 baud, 8N1.
// R15 - Mode code 00 ECB 01 CBC 10 OFB 11 CTR.
// R16 - One held request per operation, capture result.
module aes_demo_seq (
  input wire clock, // 40 MHz system clock.
  input wire rst, // Asynchronous reset, active high.
  input wire cmd_valid, // Start an operation.
  input wire [1:0] cmd_op, // Operation code.
  input wire [255:0] cmd_key, // Key; 128-bit keys sit in the upper half.
  input wire cmd_key_256, // High selects a 256-bit key.
  output reg cmd_ready_q, // Idle and able to take a command.
  input wire [7:0] msg_switch, // Switch pins that shape the last message block.
  output reg svc_req_q, // Request to the service core.
  output reg svc_decrypt_q, // High asks for decryption.
  output reg [1:0] svc_mode_q, // Cipher mode code.
  output reg svc_key_256_q, // Key length select.
  output reg [255:0] svc_key_q, // Key to the service core.
  output reg [127:0] svc_iv_q, // Initialization vector.
  output reg [127:0] svc_data_q, // Input block.
  input wire svc_done, // Service core finished; result valid.
  input wire [127:0] svc_result, // Returned block.
  output reg [127:0] last_result_q, // Most recent service core result, including intermediate CBC-MAC blocks.
  output reg uart_txd_q // Serial display line.
);
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ = 2'h1;
  localparam ST_FMT = 2'h2;

  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  localparam [9:0] BIT_CYCLES = `BIT_CYCLES;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] op_q;
  reg [127:0] counter_q;
  reg [127:0] cipher_q;
  reg [2:0] block_q;
  reg [127:0] shift_q;
  reg [5:0] char_idx_q;
  reg [7:0] sw_meta_q;
  reg [7:0] sw_sync_q;

  reg tx_state_q;
  reg [9:0] frame_q;
  reg [3:0] bit_cnt_q;
  reg [9:0] baud_cnt_q;

  reg [7:0] fmt_char;
  wire fmt_valid;
  wire fmt_ready;
  wire tx_valid;
  wire tx_take;
  wire [7:0] tx_byte;
  wire last_block;

  // Hex digit to its lower-case ASCII character.
  function [7:0] hex_char;
    input [3:0] nib;
    begin
      if (nib < `DIGIT_TEN) begin
        hex_char = `CHAR_ZERO + {4'h0, nib}; // [R2]
      end else begin
        hex_char = `CHAR_A_LOWER + {4'h0, nib - `DIGIT_TEN}; // [R2]
      end
    end
  endfunction

  // Message source; block 3 carries the synchronised switch byte.
  function [127:0] msg_block;
    input [2:0] idx;
    input [7:0] sw;
    begin
      case (idx)
        3'h0: msg_block = `MSG_BLOCK0; // [R10]
        3'h1: msg_block = `MSG_BLOCK1; // [R10]
        3'h2: msg_block = `MSG_BLOCK2; // [R10]
        default: msg_block = {`MSG_BLOCK3_HI, sw}; // [R10]
      endcase
    end
  endfunction

  // The switches come from pins, so they pass two flip-flops first.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sw_meta_q <= 8'h00;
      sw_sync_q <= 8'h00;
    end else begin
      sw_meta_q <= msg_switch;
      sw_sync_q <= sw_meta_q;
    end
  end

  // The block counter stops at the last block index, one below the configured message length.
  assign last_block = (block_q == `MSG_BLOCKS - 3'h1); // [R11] [R9]

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (svc_done && (op_q != `OP_CBC_MAC || last_block)) begin
          state_d = ST_FMT;
        end
      end
      ST_FMT: begin
        if (fmt_valid && fmt_ready && char_idx_q == `LINE_CHARS - 6'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Command acceptance, the service request and the result capture.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cmd_ready_q <= 1'b1;
      op_q <= `OP_ENCRYPT;
      svc_req_q <= 1'b0;
      svc_decrypt_q <= 1'b0;
      svc_mode_q <= `MODE_ECB;
      svc_key_256_q <= 1'b0;
      svc_key_q <= 256'h0;
      svc_iv_q <= `ZERO_IV;
      svc_data_q <= 128'h0;
      counter_q <= `COUNTER_START;
      cipher_q <= 128'h0;
      block_q <= 3'h0;
      last_result_q <= 128'h0;
    end else begin
      state_q <= state_d;
      cmd_ready_q <= (state_d == ST_IDLE);
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            op_q <= cmd_op;
            svc_req_q <= 1'b1; // [R16]
            svc_key_q <= cmd_key;
            svc_key_256_q <= cmd_key_256; // [R12]
            svc_iv_q <= `ZERO_IV; // [R6] [R8]
            block_q <= 3'h0;
            case (cmd_op)
              `OP_DECRYPT: begin
                svc_decrypt_q <= 1'b1;
                svc_mode_q <= `MODE_ECB; // [R15]
                svc_data_q <= cipher_q; // [R5]
              end
              `OP_CBC_MAC: begin
                svc_decrypt_q <= 1'b0;
                svc_mode_q <= `MODE_CBC; // [R6] [R13] [R15]
                svc_data_q <= msg_block(3'h0, sw_sync_q); // [R10]
              end
              default: begin
                svc_decrypt_q <= 1'b0;
                svc_mode_q <= `MODE_ECB; // [R15]
                svc_data_q <= counter_q; // [R4]
              end
            endcase
          end
        end
        ST_REQ: begin
          // The request stays high with stable inputs until the core finishes.
          if (svc_done) begin
            svc_req_q <= 1'b0; // [R16]
            last_result_q <= svc_result; // [R16]
            if (op_q == `OP_CBC_MAC) begin
              if (!last_block) begin
                // Next block chains on this block's ciphertext as its IV.
                block_q <= block_q + 3'h1; // [R11]
                svc_iv_q <= svc_result; // [R7] [R8]
                svc_data_q <= msg_block(block_q + 3'h1, sw_sync_q); // [R9]
                svc_req_q <= 1'b1; // [R8]
              end
            end else if (op_q == `OP_DECRYPT) begin
              svc_decrypt_q <= 1'b0;
            end else begin
              cipher_q <= svc_result; // [R5]
              counter_q <= counter_q + `COUNTER_STEP; // [R4]
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Formatter: 32 hex characters, first byte first, then CR and LF.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_q <= 128'h0;
      char_idx_q <= 6'h00;
    end else if (state_q == ST_REQ && state_d == ST_FMT) begin
      shift_q <= svc_result;
      char_idx_q <= 6'h00;
    end else if (state_q == ST_FMT && fmt_ready) begin
      // Each push moves the next nibble into the top, so the
      // upper nibble of each byte goes out before the lower one.
      shift_q <= {shift_q[123:0], 4'h0}; // [R1] [R3]
      char_idx_q <= char_idx_q + 6'h1;
    end
  end

  assign fmt_valid = (state_q == ST_FMT);

  always @* begin
    if (char_idx_q == `LINE_CHARS - 6'h2) begin
      fmt_char = `CHAR_CR;
    end else if (char_idx_q == `LINE_CHARS - 6'h1) begin
      fmt_char = `CHAR_LF;
    end else begin
      fmt_char = hex_char(shift_q[127:124]); // [R1] [R3]
    end
  end

  // Character buffer between the formatter and the serial transmitter.
  char_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_ADDR)
  ) u_char_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(fmt_valid),
    .in_ready(fmt_ready),
    .in_data(fmt_char),
    .out_valid(tx_valid),
    .out_ready(tx_take),
    .out_data(tx_byte)
  );

  assign tx_take = (tx_state_q == TX_IDLE) && tx_valid;

  // Serial transmitter: start bit, eight data bits LSB first, one stop bit.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_state_q <= TX_IDLE;
      frame_q <= 10'h3ff;
      bit_cnt_q <= 4'h0;
      baud_cnt_q <= 10'h000;
      uart_txd_q <= `IDLE_LINE;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          uart_txd_q <= `IDLE_LINE;
          if (tx_valid) begin
            frame_q <= {1'b1, tx_byte, 1'b0}; // [R14]
            bit_cnt_q <= 4'h0;
            baud_cnt_q <= 10'h000;
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          uart_txd_q <= frame_q[0]; // [R14]
          if (baud_cnt_q == BIT_CYCLES - 10'h001) begin
            baud_cnt_q <= 10'h000;
            frame_q <= {1'b1, frame_q[9:1]};
            if (bit_cnt_q == `FRAME_BITS - 4'h1) begin
              tx_state_q <= TX_IDLE; // [R14]
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end else begin
            baud_cnt_q <= baud_cnt_q + 10'h001; // [R14]
          end
        end
        default: begin
          tx_state_q <= TX_IDLE;
        end
      endcase
    end
  end
endmodule

// File: verif/aes_demo_seq_chk.sv
// Purpose: Port assertions for the AES demo sequencer.
// Assumes: One clock domain, asynchronous reset rst.
// Notes: Serial bit width is checked on low runs through a run counter.
`timescale 1ns/1ps
`include "aes_seq_consts.vh"
module aes_demo_seq_chk (
  input wire clock, // Clock.
  input wire rst, // Reset.
  input wire cmd_valid, // Command strobe.
  input wire [1:0] cmd_op, // Operation.
  input wire [255:0] cmd_key, // Key.
  input wire cmd_key_256, // Key length.
  input wire cmd_ready_q, // Idle flag.
  input wire [7:0] msg_switch, // Switches.
  input wire svc_req_q, // Request.
  input wire svc_decrypt_q, // Decrypt.
  input wire [1:0] svc_mode_q, // Mode.
  input wire svc_key_256_q, // Key length out.
  input wire [255:0] svc_key_q, // Key out.
  input wire [127:0] svc_iv_q, // Vector out.
  input wire [127:0] svc_data_q, // Data out.
  input wire svc_done, // Done.
  input wire [127:0] svc_result, // Result.
  input wire [127:0] last_result_q, // Held result.
  input wire uart_txd_q // Serial line.
);
  reg prev_q;
  reg [15:0] run_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
      run_q <= 16'h1;
    end else begin
      prev_q <= uart_txd_q;
      run_q <= (uart_txd_q == prev_q) ? run_q + 16'h1 : 16'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_cmd_start: assert property (cmd_valid && cmd_ready_q |=> svc_req_q && !cmd_ready_q)
    else $error("command not started");
  a_req_hold: assert property (svc_req_q && !svc_done |=> svc_req_q && $stable(svc_data_q) && $stable(svc_iv_q))
    else $error("request fields moved");
  a_key_hold: assert property (svc_req_q && !svc_done |=> $stable(svc_key_q) && $stable(svc_mode_q))
    else $error("key or mode moved");
  a_result_cap: assert property (svc_req_q && svc_done |=> last_result_q == $past(svc_result))
    else $error("result not captured");
  a_cbc_encrypt: assert property (svc_req_q && svc_mode_q == `MODE_CBC |-> !svc_decrypt_q)
    else $error("chained request decrypts");
  a_chain_iv: assert property (svc_req_q && svc_done && svc_mode_q == `MODE_CBC ##1 svc_req_q |-> svc_iv_q == $past(svc_result))
    else $error("vector not chained");
  a_req_ends: assert property (svc_req_q && svc_done && svc_mode_q != `MODE_CBC |=> !svc_req_q)
    else $error("request held after done");
  a_busy_quiet: assert property (!cmd_ready_q && !svc_req_q |=> !svc_req_q)
    else $error("request while formatting");
  a_idle_noreq: assert property (cmd_ready_q |-> !svc_req_q)
    else $error("request while idle");
  a_low_run: assert property (!prev_q && uart_txd_q |-> run_q % `BIT_CYCLES == 0)
    else $error("low run not whole bits");
endmodule

// File: verif/svc_core_model.sv
// Purpose: Behavioural service core with a toy reversible block cipher.
// Assumes: Decrypt requests use single-block codebook mode.
// Notes: The result bus is scrambled outside the done cycle.
`timescale 1ns/1ps
`include "aes_seq_consts.vh"
module svc_core_model (
  input wire clock, // Clock.
  input wire rst, // Reset.
  input wire [3:0] lat, // Wait cycles before done.
  input wire req, // Request level.
  input wire dec, // Decrypt select.
  input wire [1:0] mode, // Cipher mode.
  input wire key_256, // Key length.
  input wire [255:0] key, // Key.
  input wire [127:0] iv, // Vector.
  input wire [127:0] data, // Input block.
  output reg done_q, // One-cycle completion.
  output reg [127:0] result_q // Result.
);
  reg [3:0] cnt_q;
  wire [127:0] k = key_256 ? key[255:128] ^ key[127:0] : key[255:128];
  wire [127:0] x = (mode == `MODE_CBC) ? data ^ iv : data;
  wire [127:0] y = data ^ k;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
      cnt_q <= 4'h0;
      result_q <= 128'h0;
    end else begin
      done_q <= 1'b0;
      result_q <= ~result_q;
      if (req && !done_q) begin
        if (cnt_q == lat) begin
          done_q <= 1'b1;
          cnt_q <= 4'h0;
          result_q <= dec ? {y[0], y[127:1]} : {x[126:0], x[127]} ^ k;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

// File: verif/aes_demo_seq_tb.sv
// Purpose: Self-checking bench for the AES demo sequencer.
// Assumes: Service core model answers with a set latency.
// Notes: Only the head of a text line is received; a mid-run reset cuts the rest of a line short.
`timescale 1ns/1ps
`include "aes_seq_consts.vh"
module aes_demo_seq_tb;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg cmd_valid = 1'b0;
  reg [1:0] cmd_op = 2'h0;
  reg [255:0] cmd_key = 256'h0f1e2d3c4b5a69788796a5b4c3d2e1f00123456789abcdef0fedcba987654321;
  reg cmd_key_256 = 1'b0;
  reg [7:0] msg_switch = 8'h5a;
  reg [3:0] lat = 4'h0;
  wire cmd_ready_q, svc_req_q, svc_decrypt_q, svc_key_256_q, svc_done, uart_txd_q;
  wire [1:0] svc_mode_q;
  wire [255:0] svc_key_q;
  wire [127:0] svc_iv_q, svc_data_q, svc_result, last_result_q;
  integer failures = 0;
  integer total_checks = 0;
  reg [127:0] c0;
  always #12.5 clock = ~clock;
  aes_demo_seq aes_demo_seq_inst (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_key(cmd_key), .cmd_key_256(cmd_key_256), .cmd_ready_q(cmd_ready_q), .msg_switch(msg_switch),
    .svc_req_q(svc_req_q), .svc_decrypt_q(svc_decrypt_q), .svc_mode_q(svc_mode_q), .svc_key_256_q(svc_key_256_q),
    .svc_key_q(svc_key_q), .svc_iv_q(svc_iv_q), .svc_data_q(svc_data_q), .svc_done(svc_done),
    .svc_result(svc_result), .last_result_q(last_result_q), .uart_txd_q(uart_txd_q));
  svc_core_model svc_core_model_inst (.clock(clock), .rst(rst), .lat(lat), .req(svc_req_q), .dec(svc_decrypt_q),
    .mode(svc_mode_q), .key_256(svc_key_256_q), .key(svc_key_q), .iv(svc_iv_q), .data(svc_data_q),
    .done_q(svc_done), .result_q(svc_result));
  function [127:0] enc(input [127:0] v, input [127:0] k);
    enc = {v[126:0], v[127]} ^ k;
  endfunction
  task print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input string what, input [127:0] exp, input [127:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task send(input [1:0] op, input k256);
    integer n;
    n = 0;
    @(negedge clock);
    while (cmd_ready_q !== 1'b1 && n < 150000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 150000) begin
      failures++;
      print_verdict;
    end
    cmd_op = op;
    cmd_key_256 = k256;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
  endtask
  // Waits for the done cycle and checks the fields held with the request.
  task step(input [127:0] d, input [127:0] iv, input [1:0] m, input dc);
    integer n;
    n = 0;
    while (svc_done !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n >= 100) begin
      failures++;
      print_verdict;
    end
    check("data", d, svc_data_q);
    check("iv", iv, svc_iv_q);
    check("mode", m, svc_mode_q);
    check("decrypt", dc, svc_decrypt_q);
    @(negedge clock);
  endtask
  // Receives the first n_chars characters of a text line and compares them with the hex form of v.
  task rx_text(input [127:0] v, input integer n_chars);
    integer i, b, n;
    reg [7:0] c, e;
    reg [3:0] nib;
    for (i = 0; i < n_chars && i < 34; i++) begin
      n = 0;
      while (uart_txd_q !== 1'b0 && n < 20000) begin
        @(negedge clock);
        n++;
      end
      repeat (`BIT_CYCLES / 2) @(negedge clock);
      check("start", 0, uart_txd_q);
      for (b = 0; b < 8; b++) begin
        repeat (`BIT_CYCLES) @(negedge clock);
        c[b] = uart_txd_q;
      end
      repeat (`BIT_CYCLES) @(negedge clock);
      check("stop", 1, uart_txd_q);
      e = `CHAR_LF;
      nib = 4'h0;
      if (i < 32) begin
        nib = v[127 - 4 * i -: 4];
        e = (nib < `DIGIT_TEN) ? `CHAR_ZERO + nib : `CHAR_A_LOWER + nib - `DIGIT_TEN;
      end else if (i == 32) begin
        e = `CHAR_CR;
      end
      check("char", e, c);
    end
  endtask
  task t_encrypt;
    c0 = enc(`COUNTER_START, cmd_key[255:128]);
    send(`OP_ENCRYPT, 1'b0);
    step(`COUNTER_START, `ZERO_IV, `MODE_ECB, 1'b0);
    check("last", c0, last_result_q);
    rx_text(c0, 4);
    $display("test encrypt done");
  endtask
  task t_decrypt;
    send(`OP_DECRYPT, 1'b0);
    step(c0, `ZERO_IV, `MODE_ECB, 1'b1);
    check("plain", `COUNTER_START, last_result_q);
    $display("test decrypt done");
  endtask
  // Mid-run reset: aborts the text line and checks that ready, request, serial line and held result return to their reset values.
  task t_reset;
    @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    check("rst_ready", 1, cmd_ready_q);
    check("rst_req", 0, svc_req_q);
    check("rst_txd", 1, uart_txd_q);
    check("rst_last", 0, last_result_q);
    rst = 1'b0;
    $display("test reset done");
  endtask
  // Runs right after a reset, so the counter is back at its start value.
  task t_encrypt_256;
    lat = 4'h6;
    send(`OP_ENCRYPT, 1'b1);
    check("key256", 1, svc_key_256_q);
    step(`COUNTER_START, `ZERO_IV, `MODE_ECB, 1'b0);
    $display("test counter done");
  endtask
  task t_cbc;
    reg [127:0] blk [0:3];
    reg [127:0] iv;
    integer k;
    blk[0] = `MSG_BLOCK0;
    blk[1] = `MSG_BLOCK1;
    blk[2] = `MSG_BLOCK2;
    blk[3] = {`MSG_BLOCK3_HI, msg_switch};
    iv = `ZERO_IV;
    lat = 4'h3;
    send(`OP_CBC_MAC, 1'b0);
    for (k = 0; k < 4; k++) begin
      step(blk[k], iv, `MODE_CBC, 1'b0);
      iv = enc(blk[k] ^ iv, cmd_key[255:128]);
    end
    check("req_end", 0, svc_req_q);
    check("mac", iv, last_result_q);
    $display("test cbc mac done");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_encrypt;
    t_decrypt;
    t_reset;
    t_encrypt_256;
    t_reset;
    t_cbc;
    print_verdict;
  end
endmodule
bind aes_demo_seq aes_demo_seq_chk aes_demo_seq_chk_inst (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_key(cmd_key), .cmd_key_256(cmd_key_256), .cmd_ready_q(cmd_ready_q),
  .msg_switch(msg_switch), .svc_req_q(svc_req_q), .svc_decrypt_q(svc_decrypt_q), .svc_mode_q(svc_mode_q),
  .svc_key_256_q(svc_key_256_q), .svc_key_q(svc_key_q), .svc_iv_q(svc_iv_q), .svc_data_q(svc_data_q),
  .svc_done(svc_done), .svc_result(svc_result), .last_result_q(last_result_q), .uart_txd_q(uart_txd_q));
